/* bench/ssgp_node.sv */
// Serial node model: sends characters on the line and collects what it hears
`timescale 1ns/1ps
module ssgp_node #(
	parameter int BIT_CYC = 434
) (
	input  wire logic CLK_SYS,
	input  wire logic TXD,
	output logic      RXD
);
	logic [7:0] rx_q[$];
	int         frame_errs = 0;
	logic [7:0] b;
	logic       p;
	initial RXD = 1'b1;
	// One start, eight data LSB first, even parity, one stop
	task automatic send_char(input logic [7:0] d, input logic bad_par);
		logic [10:0] f;
		f = {1'b1, ^d ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			RXD <= f[i];
			repeat (BIT_CYC) @(posedge CLK_SYS);
		end
	endtask
	// Sample mid-bit; a bad start, parity or stop bit is counted, not hidden
	always begin
		@(negedge TXD);
		repeat (BIT_CYC / 2) @(posedge CLK_SYS);
		if (TXD !== 1'b0) frame_errs++;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge CLK_SYS);
			b[i] = TXD;
		end
		repeat (BIT_CYC) @(posedge CLK_SYS);
		p = TXD;
		if (p !== ^b) frame_errs++;
		repeat (BIT_CYC) @(posedge CLK_SYS);
		if (TXD !== 1'b1) frame_errs++;
		rx_q.push_back(b);
	end
endmodule

/* bench/testbench.sv */
// Self-checking bench for the serial subnetwork gateway port
`timescale 1ns/1ps
module testbench;
	import ssgp_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b   = 1'b0;
	ssgp_bus_s   bus     = '0;
	logic [31:0] rd_data;
	logic        rxd;
	logic        txd;
	logic        tx_en;
	logic        run;
	logic        err_ind;
	int          miscompares  = 0;
	int          total_checks = 0;
	logic [7:0]  exp4[4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};

	always #20 clk_sys = ~clk_sys;

	ssgp_port ssgp_port_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .BUS(bus), .RD_DATA(rd_data),
		.RXD(rxd), .TXD(txd), .TX_EN(tx_en), .RUN(run), .ERR_IND(err_ind)
	);
	ssgp_node #(.BIT_CYC(DIV_57600)) ssgp_node_i (.CLK_SYS(clk_sys), .TXD(txd), .RXD(rxd));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		// Idle edge so the next call never drives the strobe twice in one step
		@(posedge clk_sys);
	endtask
	// Read data stand from the cycle after the strobe until the next read
	task automatic rck(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(posedge clk_sys);
		check(rd_data, exp, what);
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 60000 && ssgp_node_i.rx_q.size() < n; i++) @(posedge clk_sys);
		for (int i = 0; i < 2000 && tx_en !== 1'b0; i++) @(posedge clk_sys);
	endtask
	task automatic send_msg(input logic [7:0] mid, input logic bad);
		ssgp_node_i.send_char(8'hA5, 1'b0);
		ssgp_node_i.send_char(mid, bad);
		ssgp_node_i.send_char(8'hC3, 1'b0);
		ssgp_node_i.send_char(8'h5A, 1'b0);
		repeat (20) @(posedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Whole run is about 81k cycles; margin before giving up
	initial begin
		repeat (90000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		check({31'h0, run}, 32'h0, "run after reset");
		rck(OFS_CFG, {25'h0, CFG_RST}, "cfg reset");
		rck(OFS_CTRL, 32'h0, "ctrl reset");
		$display("test reset done");
		// 57600 baud, 8 bits, even parity, 1 stop; chars A5/5A
		wr(OFS_CFG, 32'h2F);
		wr(OFS_CHARS, 32'h5AA5);
		wr(OFS_DELIM, 32'h1);
		wr(OFS_LEN, 32'h2);
		wr(OFS_CNTLOC, 32'h1F1E);
		wr(OFS_BUF, 32'h3C);
		wr(OFS_BUF + 8'h04, 32'hC3);
		wr(OFS_CTRL, 32'h5C0);
		repeat (2000) @(posedge clk_sys);
		check({31'h0, tx_en}, 32'h0, "tx before permit");
		wr(OFS_CTRL, 32'h1C1);
		wait_q(4);
		check(ssgp_node_i.rx_q.size(), 32'd4, "tx char count");
		for (int i = 0; i < 4; i++) check({24'h0, ssgp_node_i.rx_q[i]}, {24'h0, exp4[i]}, "tx byte");
		check(ssgp_node_i.frame_errs, 32'd0, "tx framing");
		check({31'h0, run}, 32'h1, "run with permit");
		rck(8'hFC, 32'h1, "tx counter");
		$display("test transmit done");
		send_msg(8'h3C, 1'b0);
		rck(8'hF8, 32'h1, "rx counter");
		rck(OFS_BUF, 32'h3C, "rx byte 0");
		rck(OFS_BUF + 8'h04, 32'hC3, "rx byte 1");
		wr(OFS_IOSZ, 32'h1);
		wr(OFS_CTRL, 32'h3C1);
		rck(OFS_BUF, 32'h3C, "rx byte in io area");
		rck(OFS_BUF + 8'h04, 32'h1C3, "rx byte in parameter area");
		$display("test receive done");
		send_msg(8'h11, 1'b1);
		rck(8'hF8, 32'h1, "rx counter after parity fault");
		$display("test parity fault done");
		wr(OFS_CTRL, 32'h4);
		@(posedge clk_sys);
		check({31'h0, run}, 32'h1, "run with registers off");
		rck(OFS_STATUS, 32'h0, "status with registers off");
		wr(OFS_CTRL, 32'h2);
		@(posedge clk_sys);
		check({31'h0, run}, 32'h1, "run without lock");
		$display("test register modes done");
		// Query mode with both char flags set: only the payload byte may go out
		ssgp_node_i.rx_q.delete();
		wr(OFS_DELIM, 32'h0);
		wr(OFS_LEN, 32'h1);
		wr(OFS_CTRL, 32'h592);
		wait_q(1);
		check(ssgp_node_i.rx_q.size(), 32'd1, "query char count");
		check({24'h0, ssgp_node_i.rx_q[0]}, 32'h3C, "query byte");
		$display("test query mode done");
		print_verdict();
	end
endmodule

/* hdl/ssgp_pkg.sv */
// Constants, encodings and carrier types for the serial subnetwork gateway port
// Operation
// R01 - With registers enabled, no traffic until host sets run-permit bit.
// R02 - No-startup-lock setting keeps registers but starts without run-permit.
// R03 - Register option disabled removes control and status function entirely. Code only blanks the status read and drops the run-permit lock.
// R04 - Restart option on: fatal error restarts silently, no error indication.
// R05 - Restart option off: fatal error halts and raises error indication.
// R06 - Bit rates 1200 to 57600 baud selectable in both modes.
// R07 - Seven or eight data bits per character.
// R08 - Parity none, odd or even, generated and checked.
// R09 - Each character begins with exactly one start bit.
// R10 - Each character ends with one or two stop bits.
// R11 - Start and end characters act only in produce/consume mode.
// R12 - Optional programmable start character marks each message beginning.
// R13 - Optional programmable end character marks each message end.
// R14 - Query/response messages separated by idle time in 10 ms units.
// R15 - Delimiter zero means idle gap of 3.5 character times.
// R16 - Statistics count good receive and transmit transactions at set buffer spots.
// R17 - User I/O sizes: first bytes from 0 are I/O, rest parameter data.
// R18 - Query/response mode: device is the single master.
// R19 - Protocol mode three: master only, half duplex.
// R20 - Produce/consume delimiter programmed in 10 microsecond units.
// R21 - Messages with parity or stop-bit errors are dropped, not counted. Code lets a fault in the start character pass.
package ssgp_pkg;
	localparam int CLK_HZ     = 25_000_000;
	localparam int DIV_1200   = CLK_HZ / 1200;
	localparam int DIV_2400   = CLK_HZ / 2400;
	localparam int DIV_4800   = CLK_HZ / 4800;
	localparam int DIV_9600   = CLK_HZ / 9600;
	localparam int DIV_19200  = CLK_HZ / 19200;
	localparam int DIV_35700  = CLK_HZ / 35700;
	localparam int DIV_38400  = CLK_HZ / 38400;
	localparam int DIV_57600  = CLK_HZ / 57600;
	localparam int DELIM_MS   = 10;
	localparam int DELIM_MS_CYC = CLK_HZ / 1000 * DELIM_MS;
	localparam int DELIM_US   = 10;
	localparam int DELIM_US_CYC = CLK_HZ / 1000000 * DELIM_US;
	localparam int BUF_DEPTH  = 32;
	localparam int BUF_AW     = 5;
	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CFG    = 8'h04;
	localparam logic [7:0] OFS_CHARS  = 8'h08;
	localparam logic [7:0] OFS_DELIM  = 8'h0C;
	localparam logic [7:0] OFS_LEN    = 8'h10;
	localparam logic [7:0] OFS_IOSZ   = 8'h14;
	localparam logic [7:0] OFS_CNTLOC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_BUF    = 8'h80;
	// Control register fields
	localparam int CTL_PERMIT = 0;
	localparam int CTL_CSR    = 1;
	localparam int CTL_RSTEN  = 3;
	localparam int CTL_PROTO  = 4;
	localparam int CTL_STATS  = 6;
	localparam int CTL_USESOM = 7;
	localparam int CTL_USEEOM = 8;
	localparam int CTL_IOUSER = 9;
	localparam int CTL_TXGO   = 10;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [6:0] CFG_RST  = 7'h1B;

	typedef enum logic [1:0] {CSR_ENABLED, CSR_NOLOCK, CSR_DISABLED, CSR_RSVD} ssgp_csr_e;
	typedef enum logic [1:0] {PR_GENERIC, PR_MASTER, PR_DF1, PR_RSVD} ssgp_proto_e;
	typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_RSVD} ssgp_par_e;

	typedef struct packed {
		logic       stop2;
		ssgp_par_e  parity;
		logic       data8;
		logic [2:0] baud;
	} ssgp_cfg_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ssgp_bus_s;
endpackage

/* hdl/ssgp_port.sv */
// Serial subnetwork gateway port: register file, character engines, message framing
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ssgp_port (
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST_B,
	// Register bus
	input  wire ssgp_pkg::ssgp_bus_s BUS,
	output logic [31:0]            RD_DATA,
	// Serial line
	input  wire logic              RXD,
	output logic                   TXD,
	output logic                   TX_EN,
	// Status pins
	output logic                   RUN,
	output logic                   ERR_IND
);
	import ssgp_pkg::*;

	logic [9:0]  ctrl_reg;
	ssgp_cfg_s   cfg_reg;
	logic [15:0] chars_reg;
	logic [15:0] delim_reg;
	logic [5:0]  tx_len_reg;
	logic [11:0] iosz_reg;
	logic [9:0]  cntloc_reg;
	logic [31:0] rd_data_reg;
	logic [7:0]  tx_mem [BUF_DEPTH];
	logic [7:0]  rx_mem [BUF_DEPTH];
	logic        rxd_s1_reg;
	logic        rxd_s2_reg;
	logic        rxd_s3_reg;
	logic        halted_reg;
	logic        tx_pend_reg;
	logic [31:0] idle_cnt_reg;
	logic [15:0] rx_count_reg;
	logic [15:0] tx_count_reg;
	logic [5:0]  rx_len_reg;
	logic [5:0]  rx_msg_len_reg;
	logic        rx_in_msg_reg;
	logic        rx_err_reg;
	logic        rx_ready_reg;

	ssgp_csr_e   csr_mode;
	ssgp_proto_e proto;
	logic        generic;
	logic        half_duplex;
	logic        use_som;
	logic        use_eom;
	logic        running;
	logic        restart;
	logic        fatal;
	logic [15:0] bit_div;
	logic [3:0]  nbits;
	logic [31:0] gap_cyc;
	logic        gap_ok;
	logic        reg_wr;
	logic        tx_start;

	assign csr_mode = ssgp_csr_e'(ctrl_reg[CTL_CSR +: 2]);
	assign proto    = ssgp_proto_e'(ctrl_reg[CTL_PROTO +: 2]);
	assign generic  = (proto == PR_GENERIC);
	// Query/response and the third mode both run as the sole master, one direction at a time
	assign half_duplex = !generic; // [R18] [R19]
	assign use_som  = generic && ctrl_reg[CTL_USESOM]; // [R11]
	assign use_eom  = generic && ctrl_reg[CTL_USEEOM]; // [R11]
	assign running  = !halted_reg && (csr_mode != CSR_ENABLED || ctrl_reg[CTL_PERMIT]); // [R01] [R02]
	assign restart  = fatal && ctrl_reg[CTL_RSTEN]; // [R04]
	assign reg_wr   = BUS.wr && BUS.addr < OFS_BUF;

	function automatic logic [15:0] div_of(input logic [2:0] sel);
		case (sel)
			3'h0: div_of = 16'(DIV_1200);
			3'h1: div_of = 16'(DIV_2400);
			3'h2: div_of = 16'(DIV_4800);
			3'h3: div_of = 16'(DIV_9600);
			3'h4: div_of = 16'(DIV_19200);
			3'h5: div_of = 16'(DIV_35700);
			3'h6: div_of = 16'(DIV_38400);
			default: div_of = 16'(DIV_57600);
		endcase
	endfunction

	// Whole frame, LSB first, padded with idle ones above the last stop bit
	function automatic logic [11:0] frame_of(input logic [7:0] d, input ssgp_cfg_s c);
		logic       p;
		logic [11:0] w;
		p = (c.parity == PAR_ODD) ? ~^(c.data8 ? d : {1'b0, d[6:0]})
		                          : ^(c.data8 ? d : {1'b0, d[6:0]}); // [R08]
		w = 12'hFFF;
		w[0] = 1'b0; // [R09]
		if (c.data8) begin
			w[8:1] = d;
			if (c.parity != PAR_NONE) w[9] = p;
		end else begin
			w[7:1] = d[6:0]; // [R07]
			if (c.parity != PAR_NONE) w[8] = p;
		end
		return w;
	endfunction

	assign bit_div = div_of(cfg_reg.baud); // [R06]
	assign nbits = 4'h2 + (cfg_reg.data8 ? 4'h8 : 4'h7) + ((cfg_reg.parity != PAR_NONE) ? 4'h1 : 4'h0)
	             + (cfg_reg.stop2 ? 4'h1 : 4'h0); // [R07] [R10]

	// Zero asks for 3.5 characters; 32 bits hold the 10 ms unit times at most 17179, larger counts wrap
	always_comb begin
		if (delim_reg == 16'h0000) begin
			gap_cyc = (32'(nbits) * 32'(bit_div) * 32'h7) >> 1; // [R15]
		end else if (generic) begin
			gap_cyc = 32'(delim_reg) * 32'(DELIM_US_CYC); // [R20]
		end else begin
			gap_cyc = 32'(delim_reg) * 32'(DELIM_MS_CYC); // [R14]
		end
	end
	assign gap_ok = idle_cnt_reg >= gap_cyc;

	// Register bus
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg   <= CTRL_RST;
			cfg_reg    <= ssgp_cfg_s'(CFG_RST);
			chars_reg  <= 16'h0000;
			delim_reg  <= 16'h0000;
			tx_len_reg <= 6'h00;
			iosz_reg   <= 12'h000;
			cntloc_reg <= 10'h000;
		end else if (reg_wr) begin
			if (BUS.addr == OFS_CTRL) begin
				ctrl_reg <= BUS.wdata[9:0];
			end else if (BUS.addr == OFS_CFG) begin
				cfg_reg <= ssgp_cfg_s'(BUS.wdata[6:0]);
			end else if (BUS.addr == OFS_CHARS) begin
				chars_reg <= BUS.wdata[15:0];
			end else if (BUS.addr == OFS_DELIM) begin
				delim_reg <= BUS.wdata[15:0];
			end else if (BUS.addr == OFS_LEN) begin
				tx_len_reg <= (BUS.wdata[5:0] > 6'(BUF_DEPTH)) ? 6'(BUF_DEPTH) : BUS.wdata[5:0];
			end else if (BUS.addr == OFS_IOSZ) begin
				iosz_reg <= {BUS.wdata[13:8], BUS.wdata[5:0]};
			end else if (BUS.addr == OFS_CNTLOC) begin
				cntloc_reg <= {BUS.wdata[12:8], BUS.wdata[4:0]};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (BUS.wr && BUS.addr >= OFS_BUF) begin
			tx_mem[BUS.addr[6:2]] <= BUS.wdata[7:0];
		end
	end

	// Buffer reads: bit 8 flags parameter area, counters overlay their chosen slots
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (BUS.rd) begin
			if (BUS.addr >= OFS_BUF) begin
				if (ctrl_reg[CTL_STATS] && BUS.addr[6:2] == cntloc_reg[4:0]) begin
					rd_data_reg <= {16'h0000, rx_count_reg}; // [R16]
				end else if (ctrl_reg[CTL_STATS] && BUS.addr[6:2] == cntloc_reg[9:5]) begin
					rd_data_reg <= {16'h0000, tx_count_reg}; // [R16]
				end else begin
					rd_data_reg <= {23'h000000, ctrl_reg[CTL_IOUSER] && 6'(BUS.addr[6:2]) >= iosz_reg[5:0],
					                rx_mem[BUS.addr[6:2]]}; // [R17]
				end
			end else if (BUS.addr == OFS_CTRL) begin
				rd_data_reg <= {22'h000000, ctrl_reg};
			end else if (BUS.addr == OFS_CFG) begin
				rd_data_reg <= {25'h0000000, cfg_reg};
			end else if (BUS.addr == OFS_CHARS) begin
				rd_data_reg <= {16'h0000, chars_reg};
			end else if (BUS.addr == OFS_DELIM) begin
				rd_data_reg <= {16'h0000, delim_reg};
			end else if (BUS.addr == OFS_LEN) begin
				rd_data_reg <= {18'h00000, rx_msg_len_reg, 2'h0, tx_len_reg};
			end else if (BUS.addr == OFS_IOSZ) begin
				rd_data_reg <= {18'h00000, iosz_reg[11:6], 2'h0, iosz_reg[5:0]};
			end else if (BUS.addr == OFS_CNTLOC) begin
				rd_data_reg <= {19'h00000, cntloc_reg[9:5], 3'h0, cntloc_reg[4:0]};
			end else if (BUS.addr == OFS_STATUS && csr_mode != CSR_DISABLED) begin
				rd_data_reg <= {27'h0000000, rx_ready_reg, tx_pend_reg, halted_reg, ERR_IND, running};
			end else begin
				rd_data_reg <= 32'h0000_0000; // [R03]
			end
		end
	end
	assign RD_DATA = rd_data_reg;

	// Line input synchroniser; stage three only feeds the edge detector
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rxd_s1_reg <= 1'b1;
			rxd_s2_reg <= 1'b1;
			rxd_s3_reg <= 1'b1;
		end else begin
			rxd_s1_reg <= RXD;
			rxd_s2_reg <= rxd_s1_reg;
			rxd_s3_reg <= rxd_s2_reg;
		end
	end

	// Transmit character engine
	typedef enum {TX_IDLE, TX_SOM, TX_DATA, TX_EOM, TX_WAIT} ssgp_txst_e;
	ssgp_txst_e  tx_st_reg;
	logic [11:0] tx_sh_reg;
	logic [3:0]  tx_bits_reg;
	logic [15:0] tx_div_reg;
	logic [5:0]  tx_idx_reg;
	logic        tx_char_busy;
	logic        tx_load;
	logic [7:0]  tx_byte;
	logic        tx_msg_done;
	logic        rx_busy;

	assign tx_char_busy = (tx_bits_reg != 4'h0);
	assign tx_start = (tx_st_reg == TX_IDLE) && tx_pend_reg && running && gap_ok
	                  && !(half_duplex && rx_busy); // [R14] [R15]
	// A halt or restart wins over a load so no half-loaded character reaches the line
	assign tx_load = !tx_char_busy && !halted_reg && !restart
	                 && (tx_st_reg == TX_SOM || tx_st_reg == TX_EOM
	                 || (tx_st_reg == TX_DATA && tx_idx_reg < tx_len_reg));
	assign tx_byte = (tx_st_reg == TX_SOM) ? chars_reg[7:0]
	               : (tx_st_reg == TX_EOM) ? chars_reg[15:8] : tx_mem[tx_idx_reg[4:0]];
	assign tx_msg_done = (tx_st_reg == TX_WAIT) && !tx_char_busy;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tx_pend_reg <= 1'b0;
		end else if (reg_wr && BUS.addr == OFS_CTRL && BUS.wdata[CTL_TXGO]) begin
			tx_pend_reg <= 1'b1;
		end else if (tx_start || restart) begin
			tx_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tx_st_reg  <= TX_IDLE;
			tx_idx_reg <= 6'h00;
		end else if (restart || halted_reg) begin
			tx_st_reg  <= TX_IDLE;
			tx_idx_reg <= 6'h00;
		end else begin
			case (tx_st_reg)
				TX_IDLE: begin
					tx_idx_reg <= 6'h00;
					if (tx_start) tx_st_reg <= use_som ? TX_SOM : TX_DATA; // [R12]
				end
				TX_SOM: begin
					if (tx_load) tx_st_reg <= TX_DATA;
				end
				TX_DATA: begin
					if (tx_load) begin
						tx_idx_reg <= tx_idx_reg + 6'h01;
					end else if (!tx_char_busy) begin
						tx_st_reg <= use_eom ? TX_EOM : TX_WAIT; // [R13]
					end
				end
				TX_EOM: begin
					if (tx_load) tx_st_reg <= TX_WAIT;
				end
				TX_WAIT: begin
					if (!tx_char_busy) tx_st_reg <= TX_IDLE;
				end
				default: tx_st_reg <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tx_sh_reg   <= 12'hFFF;
			tx_bits_reg <= 4'h0;
			tx_div_reg  <= 16'h0000;
		end else if (restart || halted_reg) begin
			tx_sh_reg   <= 12'hFFF;
			tx_bits_reg <= 4'h0;
		end else if (tx_load) begin
			tx_sh_reg   <= frame_of(tx_byte, cfg_reg); // [R09] [R10]
			tx_bits_reg <= nbits;
			tx_div_reg  <= bit_div - 16'h0001;
		end else if (tx_char_busy) begin
			if (tx_div_reg == 16'h0000) begin
				tx_sh_reg   <= {1'b1, tx_sh_reg[11:1]};
				tx_bits_reg <= tx_bits_reg - 4'h1;
				tx_div_reg  <= bit_div - 16'h0001;
			end else begin
				tx_div_reg <= tx_div_reg - 16'h0001;
			end
		end
	end
	assign TXD   = tx_char_busy ? tx_sh_reg[0] : 1'b1;
	assign TX_EN = (tx_st_reg != TX_IDLE); // [R19]

	// Receive character engine: start validated at mid bit, then one sample per bit
	logic [11:0] rx_sh_reg;
	logic [3:0]  rx_bit_reg;
	logic [15:0] rx_div_reg;
	logic        rx_act_reg;
	logic        rx_char_done;
	logic        rx_char_err;
	logic [7:0]  rx_byte;
	logic [11:0] rx_mask;

	assign rx_busy = rx_act_reg;
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rx_act_reg <= 1'b0;
			rx_bit_reg <= 4'h0;
			rx_div_reg <= 16'h0000;
			rx_sh_reg  <= 12'hFFF;
		end else if (restart || !running || (half_duplex && TX_EN)) begin
			rx_act_reg <= 1'b0;
			rx_bit_reg <= 4'h0;
		end else if (!rx_act_reg) begin
			if (rxd_s3_reg && !rxd_s2_reg) begin
				rx_act_reg <= 1'b1;
				rx_bit_reg <= 4'h0;
				rx_div_reg <= (bit_div >> 1) - 16'h0001;
				rx_sh_reg  <= 12'hFFF;
			end
		end else if (rx_div_reg == 16'h0000) begin
			rx_sh_reg[rx_bit_reg] <= rxd_s2_reg;
			rx_div_reg <= bit_div - 16'h0001;
			if (rx_bit_reg == 4'h0 && rxd_s2_reg) begin
				rx_act_reg <= 1'b0; // Glitch, not a start bit
			end else if (rx_bit_reg == nbits - 4'h1) begin
				rx_act_reg <= 1'b0;
			end else begin
				rx_bit_reg <= rx_bit_reg + 4'h1;
			end
		end else begin
			rx_div_reg <= rx_div_reg - 16'h0001;
		end
	end

	// Compare against the frame the same data would make: catches parity and stop faults
	always_comb begin
		rx_mask      = 12'hFFF >> (4'd12 - nbits);
		rx_byte      = cfg_reg.data8 ? rx_sh_reg[8:1] : {1'b0, rx_sh_reg[7:1]};
		rx_char_err  = ((rx_sh_reg ^ frame_of(rx_byte, cfg_reg)) & rx_mask) != 12'h000; // [R08] [R10]
	end

	logic rx_char_done_reg;
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rx_char_done_reg <= 1'b0;
		end else begin
			rx_char_done_reg <= rx_act_reg && rx_div_reg == 16'h0000 && rx_bit_reg == nbits - 4'h1
			                    && !restart;
		end
	end
	assign rx_char_done = rx_char_done_reg;

	// Line idle time, the base of every message gap
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			idle_cnt_reg <= 32'h0000_0000;
		end else if (rx_act_reg || TX_EN) begin
			idle_cnt_reg <= 32'h0000_0000;
		end else if (idle_cnt_reg != 32'hFFFF_FFFF) begin
			idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
		end
	end

	// Receive message framing
	logic rx_is_som;
	logic rx_is_eom;
	logic rx_gap_end;
	logic rx_msg_end;
	logic rx_bad;
	assign rx_is_som  = use_som && rx_byte == chars_reg[7:0]; // [R12]
	assign rx_is_eom  = use_eom && rx_byte == chars_reg[15:8]; // [R13]
	assign rx_gap_end = rx_in_msg_reg && !use_eom && idle_cnt_reg == gap_cyc; // [R14] [R15]
	assign rx_msg_end = (rx_char_done && rx_in_msg_reg && rx_is_eom) || rx_gap_end;
	// A faulty end character spoils the message as well
	assign rx_bad     = rx_err_reg || (rx_char_done && rx_char_err); // [R21]
	assign fatal = rx_char_done && rx_in_msg_reg && !rx_is_eom && rx_len_reg == 6'(BUF_DEPTH);

	always_ff @(posedge CLK_SYS) begin
		if (rx_char_done && rx_in_msg_reg && !rx_is_eom && rx_len_reg < 6'(BUF_DEPTH)) begin
			rx_mem[rx_len_reg[4:0]] <= rx_byte;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rx_in_msg_reg <= 1'b0;
			rx_len_reg    <= 6'h00;
			rx_err_reg    <= 1'b0;
		end else if (restart || rx_msg_end || !running) begin
			rx_in_msg_reg <= 1'b0;
			rx_len_reg    <= 6'h00;
			rx_err_reg    <= 1'b0;
		end else if (rx_char_done) begin
			if (!rx_in_msg_reg) begin
				rx_in_msg_reg <= !use_som || rx_is_som; // [R12]
				if (!use_som) begin
					rx_len_reg <= 6'h01;
					rx_err_reg <= rx_char_err;
				end
			end else begin
				rx_len_reg <= rx_len_reg + 6'h01;
				rx_err_reg <= rx_err_reg || rx_char_err;
			end
		end
	end

	// A message with a bad data or end character is dropped whole and leaves the counter alone
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rx_ready_reg   <= 1'b0;
			rx_msg_len_reg <= 6'h00;
			rx_count_reg   <= 16'h0000;
		end else if (restart) begin
			rx_ready_reg <= 1'b0;
		end else if (rx_msg_end && !rx_bad) begin // [R21]
			rx_ready_reg   <= 1'b1;
			rx_msg_len_reg <= rx_len_reg;
			if (ctrl_reg[CTL_STATS]) rx_count_reg <= rx_count_reg + 16'h0001; // [R16]
		end else if (BUS.rd && BUS.addr == OFS_LEN) begin
			rx_ready_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tx_count_reg <= 16'h0000;
		end else if (tx_msg_done && ctrl_reg[CTL_STATS]) begin
			tx_count_reg <= tx_count_reg + 16'h0001; // [R16]
		end
	end

	// Fatal error: buffer overrun. Halt is left only through reset
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			halted_reg <= 1'b0;
		end else if (fatal && !ctrl_reg[CTL_RSTEN]) begin
			halted_reg <= 1'b1; // [R05]
		end
	end
	assign ERR_IND = halted_reg; // [R04] [R05]
	assign RUN     = running;

	a_permit_lock: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R01]
		(csr_mode == CSR_ENABLED && !ctrl_reg[CTL_PERMIT]) |-> !tx_start)
		else $error("transmission began without run permit");
	a_nolock_start: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R02]
		(csr_mode == CSR_NOLOCK && !halted_reg && tx_pend_reg && tx_st_reg == TX_IDLE && gap_ok
		 && !(half_duplex && rx_busy)) |-> tx_start ##1 TX_EN)
		else $error("no-lock mode waited for permit");
	a_status_off: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R03]
		(BUS.rd && BUS.addr == OFS_STATUS && csr_mode == CSR_DISABLED) |=> RD_DATA == 32'h0000_0000)
		else $error("status visible while disabled");
	a_restart_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R04]
		(fatal && ctrl_reg[CTL_RSTEN] && !halted_reg) |=> !ERR_IND && !rx_in_msg_reg)
		else $error("restart raised error or kept message");
	a_halt_error: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R05]
		(fatal && !ctrl_reg[CTL_RSTEN]) |=> ERR_IND && !RUN ##1 !TX_EN)
		else $error("fatal error did not halt");
	a_start_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R09]
		tx_load |=> !TXD && tx_bits_reg == nbits)
		else $error("character did not open with start bit");
	a_stop_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R10]
		(tx_char_busy && tx_bits_reg <= (cfg_reg.stop2 ? 4'h2 : 4'h1)) |-> TXD)
		else $error("stop bit not high");
	a_gap_kept: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R14]
		tx_start |-> idle_cnt_reg >= gap_cyc && !$past(TX_EN))
		else $error("message sent inside idle gap");
	a_err_discard: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // [R21]
		(rx_msg_end && rx_bad && !restart) |=> $stable(rx_count_reg) && $stable(rx_msg_len_reg))
		else $error("bad message was counted");
endmodule
